// ===== rtl/sffp_cfg.svh
/*
  offsets, field positions, reset values and timing figures of the
  static friction fault predictor.
  assumes: included by bare name from the package and the top module.
*/
`ifndef SFFP_CFG_SVH
`define SFFP_CFG_SVH

// ------------------------------------------------
// timing
// ------------------------------------------------
`define SFFP_CLK_HZ 50000000
`define SFFP_RUN_HOURS 3
`define SFFP_SEC_PER_HOUR 3600

// ------------------------------------------------
// register byte offsets
// ------------------------------------------------
`define SFFP_OFS_CTRL 8'h00
`define SFFP_OFS_AVG 8'h04
`define SFFP_OFS_DEV 8'h08
`define SFFP_OFS_STRETCH 8'h0c
`define SFFP_OFS_STATUS 8'h10
`define SFFP_OFS_UPPER 8'h14
`define SFFP_OFS_LOWER 8'h18
`define SFFP_OFS_IRQ_STAT 8'h1c
`define SFFP_OFS_IRQ_MASK 8'h20

// ------------------------------------------------
// control fields
// ------------------------------------------------
`define SFFP_MODE_LSB 0
`define SFFP_DIR_BIT 4
`define SFFP_MULT_LSB 8
`define SFFP_SRST_BIT 31

// ------------------------------------------------
// codes and reset values
// ------------------------------------------------
`define SFFP_MODE_OFF 4'h0
`define SFFP_MODE_AUTO 4'h1
`define SFFP_MODE_MANUAL 4'h2
`define SFFP_MODE_RESET 4'h3
`define SFFP_MULT_RST 4'h0
`define SFFP_MULT_SUBST 4'h5
`define SFFP_PST_OFF 4'h0
`define SFFP_PST_EXEC 4'h1
`define SFFP_PST_WARN 4'h2
`define SFFP_IRQ_W 3

`endif

// ===== rtl/sffp_pkg.sv
/*
  types of the static friction fault predictor.
  assumes: nothing beyond the config header.
*/
`include "sffp_cfg.svh"

package sffp_pkg;

  // ------------------------------------------------
  // types
  // ------------------------------------------------
  typedef logic [3:0] sffp_mode_t;
  typedef logic [3:0] sffp_pst_t;
  typedef enum logic [2:0] {
    SFFP_IDLE, SFFP_GATHER, SFFP_CALC, SFFP_ROOT, SFFP_DONE
  } sffp_auto_t;

endpackage

// ===== rtl/sffp_top.sv
/*
  static friction fault predictor: avalon-mm register slave, automatic
  threshold learner (mean, deviation by shift-subtract root), band
  comparator and interrupt logic.
  assumes: friction, estimator, run and travel inputs come from logic on
  clk_i; stored_mode_i is stable when rstn_i is released.
*/
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "sffp_cfg.svh"

module sffp_top #(
  parameter int F_W = 16,
  parameter int SMP_LOG2 = 8,
  parameter logic [39:0] RUN_CYCLES =
    40'(64'(`SFFP_RUN_HOURS) * 64'(`SFFP_SEC_PER_HOUR) * 64'(`SFFP_CLK_HZ))
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic signed [F_W-1:0] friction_i,
  input wire logic friction_valid_i,
  input wire logic est_done_fwd_i,
  input wire logic est_done_rev_i,
  input wire logic running_i,
  input wire logic [31:0] travel_i,
  input wire sffp_pkg::sffp_mode_t stored_mode_i,
  output logic machine_diagnosis_warning_o,
  output sffp_pkg::sffp_pst_t pred_state_o,
  output logic irq_o
);
  import sffp_pkg::*;

  localparam int TW = F_W + 6;
  localparam int SW = F_W + SMP_LOG2;
  localparam int RW = 2 * F_W;
  localparam int QW = RW + SMP_LOG2;

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  // byte-lane merge of a write into a register word
  function automatic logic [31:0] be_merge(input logic [31:0] cur, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // one band limit from average, deviation and multiplier
  function automatic logic signed [TW-1:0] band(input logic signed [F_W-1:0] a,
                                                input logic [F_W-1:0] d, input logic [3:0] m,
                                                input logic up);
    logic [3:0] em;
    logic [TW-1:0] p;
    em = (m == 4'h0) ? `SFFP_MULT_SUBST : m;
    p = TW'(d) * TW'(em);
    return up ? (TW'(a) + p) : (TW'(a) - p);
  endfunction

  // ------------------------------------------------
  // state
  // ------------------------------------------------
  sffp_mode_t mode_q;
  logic dir_q;
  logic [3:0] mult_q;
  logic signed [F_W-1:0] avg_q;
  logic [F_W-1:0] dev_q;
  logic [31:0] stretch_q;
  logic wait_q, srst_q, boot_q, thr_valid_q, warn_q, warn_d, irq_q;
  logic [31:0] rdata_q, rd_mux;
  logic signed [TW-1:0] upper_q, lower_q, fx;
  logic [`SFFP_IRQ_W-1:0] istat_q, imask_q, ev;
  sffp_pst_t pst_q;
  sffp_auto_t st_q;
  logic [39:0] run_q;
  logic [SMP_LOG2-1:0] cnt_q;
  logic signed [SW-1:0] sum_q, sum_sh;
  logic [QW-1:0] sumsq_q, msq;
  logic signed [RW-1:0] sq_w, mm_w;
  logic [RW:0] var_w;
  logic [RW-1:0] rad_q, res_q, bit_q, trial;
  logic signed [F_W-1:0] mean_w;
  logic acc, wr, gate_ok, active, thr_clr, learn_done;
  logic [31:0] ctrl_word, wmerge;

  // ------------------------------------------------
  // avalon-mm slave
  // ------------------------------------------------
  // one wait cycle, answer on the second
  assign acc = (avs_read_i | avs_write_i) & ~wait_q;
  assign wr = avs_write_i & acc;
  assign ctrl_word = {20'h0, mult_q, 3'h0, dir_q, mode_q};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    unique case (avs_address_i)
      `SFFP_OFS_CTRL: rd_mux = ctrl_word;
      `SFFP_OFS_AVG: rd_mux = 32'(avg_q);
      `SFFP_OFS_DEV: rd_mux = 32'(dev_q);
      `SFFP_OFS_STRETCH: rd_mux = stretch_q;
      `SFFP_OFS_STATUS: rd_mux = {26'h0, thr_valid_q, warn_q, pst_q};
      `SFFP_OFS_UPPER: rd_mux = 32'(upper_q);
      `SFFP_OFS_LOWER: rd_mux = 32'(lower_q);
      `SFFP_OFS_IRQ_STAT: rd_mux = 32'(istat_q);
      `SFFP_OFS_IRQ_MASK: rd_mux = 32'(imask_q);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0;
    end else if (avs_read_i & wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  assign wmerge = be_merge(rd_mux, avs_writedata_i, avs_byteenable_i);

  // ------------------------------------------------
  // control and settings
  // ------------------------------------------------
  assign thr_clr = srst_q && (mode_q == `SFFP_MODE_RESET);
  assign learn_done = (st_q == SFFP_DONE);

  // boot marker and software reset pulse
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_q <= 1'b1;
      srst_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      srst_q <= wr && (avs_address_i == `SFFP_OFS_CTRL) && wmerge[`SFFP_SRST_BIT];
    end
  end

  // mode field, hardware updates win over software
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= `SFFP_MODE_OFF;
      dir_q <= 1'b0;
      mult_q <= `SFFP_MULT_RST;
    end else if (boot_q) begin
      mode_q <= (stored_mode_i == `SFFP_MODE_RESET) ? `SFFP_MODE_AUTO : stored_mode_i;
    end else if (thr_clr) begin
      mode_q <= `SFFP_MODE_AUTO;
    end else if (learn_done) begin
      mode_q <= `SFFP_MODE_MANUAL;
    end else if (wr && avs_address_i == `SFFP_OFS_CTRL) begin
      mode_q <= wmerge[`SFFP_MODE_LSB +: 4];
      dir_q <= wmerge[`SFFP_DIR_BIT];
      mult_q <= wmerge[`SFFP_MULT_LSB +: 4];
    end
  end

  // average, deviation and stretch distance
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avg_q <= '0;
      dev_q <= '0;
      stretch_q <= 32'h0;
    end else if (thr_clr) begin
      avg_q <= '0;
      dev_q <= '0;
    end else if (learn_done) begin
      avg_q <= mean_w;
      dev_q <= res_q[F_W-1:0];
    end else if (wr) begin
      if (avs_address_i == `SFFP_OFS_AVG) begin
        avg_q <= wmerge[F_W-1:0];
      end
      if (avs_address_i == `SFFP_OFS_DEV) begin
        dev_q <= wmerge[F_W-1:0];
      end
      if (avs_address_i == `SFFP_OFS_STRETCH) begin
        stretch_q <= wmerge;
      end
    end
  end

  // ------------------------------------------------
  // learning gate
  // ------------------------------------------------
  // continuous run time, restarts when running stops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q <= 40'h0;
    end else if (!running_i) begin
      run_q <= 40'h0;
    end else if (run_q != RUN_CYCLES) begin
      run_q <= run_q + 40'h1;
    end
  end

  assign gate_ok = (run_q == RUN_CYCLES) && (dir_q ? est_done_rev_i : est_done_fwd_i)
                   && (travel_i >= stretch_q);

  // ------------------------------------------------
  // automatic threshold learner
  // ------------------------------------------------
  assign sq_w = friction_i * friction_i;
  assign sum_sh = sum_q >>> SMP_LOG2;
  assign mean_w = sum_sh[F_W-1:0];
  assign msq = sumsq_q >> SMP_LOG2;
  assign mm_w = mean_w * mean_w;
  assign var_w = {1'b0, msq[RW-1:0]} - {1'b0, mm_w};
  assign trial = res_q + bit_q;

  // sample mean and variance, then integer root
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= SFFP_IDLE;
      cnt_q <= '0;
      sum_q <= '0;
      sumsq_q <= '0;
      rad_q <= '0;
      res_q <= '0;
      bit_q <= '0;
    end else if (mode_q != `SFFP_MODE_AUTO || thr_clr) begin
      st_q <= SFFP_IDLE;
    end else begin
      unique case (st_q)
        SFFP_IDLE: begin
          cnt_q <= '0;
          sum_q <= '0;
          sumsq_q <= '0;
          st_q <= SFFP_GATHER;
        end
        SFFP_GATHER: begin
          if (friction_valid_i && gate_ok) begin
            sum_q <= sum_q + SW'(friction_i);
            sumsq_q <= sumsq_q + QW'($unsigned(sq_w));
            cnt_q <= cnt_q + 1'b1;
            if (&cnt_q) begin
              st_q <= SFFP_CALC;
            end
          end
        end
        SFFP_CALC: begin
          rad_q <= var_w[RW] ? '0 : var_w[RW-1:0];
          res_q <= '0;
          bit_q <= RW'(1) << (RW - 2);
          st_q <= SFFP_ROOT;
        end
        SFFP_ROOT: begin
          if (bit_q == '0) begin
            st_q <= SFFP_DONE;
          end else begin
            if (rad_q >= trial) begin
              rad_q <= rad_q - trial;
              res_q <= (res_q >> 1) + bit_q;
            end else begin
              res_q <= res_q >> 1;
            end
            bit_q <= bit_q >> 2;
          end
        end
        SFFP_DONE: begin
          st_q <= SFFP_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------
  // thresholds and band compare
  // ------------------------------------------------
  // limits follow the settings while in manual mode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_q <= '0;
      lower_q <= '0;
      thr_valid_q <= 1'b0;
    end else if (thr_clr) begin
      upper_q <= '0;
      lower_q <= '0;
      thr_valid_q <= 1'b0;
    end else if (mode_q == `SFFP_MODE_MANUAL) begin
      upper_q <= band(avg_q, dev_q, mult_q, 1'b1);
      lower_q <= band(avg_q, dev_q, mult_q, 1'b0);
      thr_valid_q <= 1'b1;
    end else begin
      thr_valid_q <= 1'b0;
    end
  end

  assign active = (mode_q == `SFFP_MODE_MANUAL) && thr_valid_q;
  assign fx = TW'(friction_i);

  // warning level, re-judged on every friction sample
  always_comb begin
    warn_d = warn_q;
    if (!active) begin
      warn_d = 1'b0;
    end else if (friction_valid_i) begin
      warn_d = (fx > upper_q)
               || (fx < lower_q);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      warn_q <= 1'b0;
      pst_q <= `SFFP_PST_OFF;
    end else begin
      warn_q <= warn_d;
      pst_q <= !active ? `SFFP_PST_OFF : (warn_d ? `SFFP_PST_WARN : `SFFP_PST_EXEC);
    end
  end

  // ------------------------------------------------
  // interrupts
  // ------------------------------------------------
  assign ev = {learn_done, warn_q & ~warn_d, warn_d & ~warn_q};

  // sticky status, a new event wins over its clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      istat_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr && avs_address_i == `SFFP_OFS_IRQ_STAT) begin
        istat_q <= (istat_q & ~wmerge[`SFFP_IRQ_W-1:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
      if (wr && avs_address_i == `SFFP_OFS_IRQ_MASK) begin
        imask_q <= wmerge[`SFFP_IRQ_W-1:0];
      end
      irq_q <= |(istat_q & imask_q);
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign machine_diagnosis_warning_o = warn_q;
  assign pred_state_o = pst_q;
  assign irq_o = irq_q;

endmodule

// ===== dv/sffp_fe_mdl.sv
/*
  friction estimator model: sends one-cycle friction samples on request.
  assumes: requests come from the bench at rising edges of clk_i.
*/
`timescale 1ns/100ps
module sffp_fe_mdl (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic [15:0] val_i,
  output logic [15:0] friction_o,
  output logic friction_valid_o
);
  // sample pulse; outside a sample the value toggles, so nothing stale looks valid
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      friction_valid_o <= 1'b0;
      friction_o <= 16'h0000;
    end else begin
      friction_valid_o <= req_i;
      friction_o <= req_i ? val_i : ~friction_o;
    end
  end
endmodule

// ===== dv/sffp_chk.sv
/*
  checker of the friction predictor ports: bus answer timing, warning cause,
  status nibble.
  assumes: bound to sffp_top, one clock domain.
*/
`timescale 1ns/100ps
`include "sffp_cfg.svh"
module sffp_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic friction_valid_i,
  input wire logic machine_diagnosis_warning_o,
  input wire sffp_pkg::sffp_pst_t pred_state_o,
  input wire logic irq_o
);
  import sffp_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  req_ans_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer one cycle after a request");
  ans_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i) && $past(avs_waitrequest_o))
    else $error("answer without a pending request");
  ans_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  idle_wait_a: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("answer while idle");
  rdata_hold_a: assert property (avs_waitrequest_o |-> $stable(avs_readdata_o))
    else $error("read data moved outside an answer");
  // ----------------------------------------
  // warning and status
  // ----------------------------------------
  warn_cause_a: assert property ($rose(machine_diagnosis_warning_o) |-> $past(friction_valid_i))
    else $error("warning raised without a friction sample");
  pst_follow_a: assert property ((pred_state_o == `SFFP_PST_WARN) == machine_diagnosis_warning_o)
    else $error("status nibble does not follow the warning");
  pst_legal_a: assert property (pred_state_o inside {`SFFP_PST_OFF, `SFFP_PST_EXEC, `SFFP_PST_WARN})
    else $error("status nibble out of range");
  cover property ($rose(machine_diagnosis_warning_o));
  cover property ($fell(machine_diagnosis_warning_o));
  cover property ($rose(irq_o));
endmodule
bind sffp_top sffp_chk i_sffp_chk (.clk_i, .rstn_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .friction_valid_i, .machine_diagnosis_warning_o, .pred_state_o, .irq_o);

// ===== dv/tb_top.sv
/*
  self-checking bench of the friction predictor: table of manual bands,
  then mode, bus, learning, interrupt and reset cases.
  assumes: design built with short learning counts.
*/
`timescale 1ns/100ps
`include "sffp_cfg.svh"
module tb_top;
  import sffp_pkg::*;
  typedef struct {int avg; int dev; int mult; int fric; logic warn;} sffp_row_t;
  logic clk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, req = 1'b0;
  logic est_done_fwd_i = 1'b0, est_done_rev_i = 1'b0, running_i = 1'b0;
  logic friction_valid_i, machine_diagnosis_warning_o, avs_waitrequest_o, irq_o;
  logic [7:0] avs_address_i = 8'h00;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0, travel_i = 32'h0, avs_readdata_o, d;
  logic [15:0] val = 16'h0, friction_i;
  sffp_mode_t stored_mode_i = 4'h0;
  sffp_pst_t pred_state_o;
  sffp_mode_t offm[3] = '{4'h0, 4'h1, 4'h4};
  int num_errors = 0, total_checks = 0, cycles = 0, m;
  int smp[4] = '{10, 10, 14, 14};
  sffp_row_t rows[8] = '{'{100, 10, 0, 151, 1}, '{100, 10, 0, 150, 0}, '{100, 10, 0, 49, 1},
    '{100, 10, 0, 50, 0}, '{20, 10, 3, -11, 1}, '{20, 10, 3, -10, 0}, '{0, 2, 15, 31, 1}, '{0, 2, 15, -30, 0}};

  sffp_top #(.SMP_LOG2(2), .RUN_CYCLES(40'h14)) i_sffp_top (.clk_i, .rstn_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .friction_i,
    .friction_valid_i, .est_done_fwd_i, .est_done_rev_i, .running_i, .travel_i, .stored_mode_i,
    .machine_diagnosis_warning_o, .pred_state_o, .irq_o);
  sffp_fe_mdl i_sffp_fe_mdl (.clk_i, .rstn_i, .req_i(req), .val_i(val), .friction_o(friction_i),
    .friction_valid_o(friction_valid_i));

  // clock and hang guard
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 20000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one bus cycle; held until waitrequest is seen low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    avs_write_i <= we;
    avs_read_i <= !we;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(d, e);
  endtask
  // one sample through the model, then wait for warning and status
  task automatic send(input int v);
    @(posedge clk_i);
    req <= 1'b1;
    val <= 16'(v);
    @(posedge clk_i);
    req <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic rst(input sffp_mode_t md);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    stored_mode_i <= md;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rst(4'h0);
    foreach (rows[i]) begin
      m = (rows[i].mult == 0) ? 5 : rows[i].mult;
      wr(`SFFP_OFS_AVG, 32'(rows[i].avg));
      wr(`SFFP_OFS_DEV, 32'(rows[i].dev));
      wr(`SFFP_OFS_CTRL, 32'h2 | (32'(rows[i].mult) << 8));
      rdchk(`SFFP_OFS_UPPER, 32'(rows[i].avg + rows[i].dev * m));
      rdchk(`SFFP_OFS_LOWER, 32'(rows[i].avg - rows[i].dev * m));
      send(rows[i].fric);
      cmp(machine_diagnosis_warning_o, rows[i].warn);
      cmp(pred_state_o, rows[i].warn ? 32'h2 : 32'h1);
      rdchk(`SFFP_OFS_STATUS, rows[i].warn ? 32'h32 : 32'h21);
    end
    rdchk(`SFFP_OFS_IRQ_STAT, 32'h3);
    $display("test table done");
    foreach (offm[i]) begin
      wr(`SFFP_OFS_CTRL, {28'h0, offm[i]});
      send(500);
      cmp(machine_diagnosis_warning_o, 32'h0);
      cmp(pred_state_o, 32'h0);
    end
    avs_byteenable_i <= 4'h1;
    wr(`SFFP_OFS_AVG, 32'h0000ffff);
    avs_byteenable_i <= 4'hf;
    rdchk(`SFFP_OFS_AVG, 32'h000000ff);
    wr(8'h40, 32'h12345678);
    rdchk(8'h40, 32'h0);
    $display("test modes and bus done");
    wr(`SFFP_OFS_IRQ_STAT, 32'h7);
    wr(`SFFP_OFS_STRETCH, 32'h5);
    running_i <= 1'b1;
    est_done_rev_i <= 1'b1;
    wr(`SFFP_OFS_CTRL, 32'h1);
    for (int p = 0; p < 3; p++) begin
      travel_i <= (p == 0) ? 32'h4 : 32'h5;
      est_done_fwd_i <= (p != 1);
      foreach (smp[k]) send(smp[k]);
      if (p < 2) rdchk(`SFFP_OFS_CTRL, 32'h1);
    end
    for (int i = 0; i < 30 && d[3:0] !== 4'h2; i++) bus(1'b0, `SFFP_OFS_CTRL, 32'h0);
    cmp(d, 32'h2);
    rdchk(`SFFP_OFS_AVG, 32'hc);
    rdchk(`SFFP_OFS_DEV, 32'h2);
    rdchk(`SFFP_OFS_UPPER, 32'h16);
    rdchk(`SFFP_OFS_IRQ_STAT, 32'h4);
    cmp(irq_o, 32'h0);
    wr(`SFFP_OFS_IRQ_MASK, 32'h4);
    repeat (2) @(negedge clk_i);
    cmp(irq_o, 32'h1);
    wr(`SFFP_OFS_IRQ_STAT, 32'h4);
    repeat (2) @(negedge clk_i);
    cmp(irq_o, 32'h0);
    rdchk(`SFFP_OFS_IRQ_STAT, 32'h0);
    $display("test learning and irq done");
    wr(`SFFP_OFS_CTRL, 32'h3);
    wr(`SFFP_OFS_CTRL, 32'h80000003);
    rdchk(`SFFP_OFS_CTRL, 32'h1);
    rdchk(`SFFP_OFS_AVG, 32'h0);
    rdchk(`SFFP_OFS_UPPER, 32'h0);
    running_i <= 1'b0;
    rst(4'h3);
    rdchk(`SFFP_OFS_CTRL, 32'h1);
    rst(4'h0);
    rdchk(`SFFP_OFS_CTRL, 32'h0);
    rdchk(`SFFP_OFS_AVG, 32'h0);
    rdchk(`SFFP_OFS_DEV, 32'h0);
    rdchk(`SFFP_OFS_STATUS, 32'h0);
    rdchk(`SFFP_OFS_IRQ_MASK, 32'h0);
    cmp(machine_diagnosis_warning_o, 32'h0);
    $display("test resets done");
    conclude();
  end
endmodule
